/* logic/e1_prbs_generator_detector.sv */
// E1 pseudo-random pattern generator and detector with its registers.
// Assumes bit-rate enables for both directions, synchronous to MCLK.
//
// Operation
// - Receive inversion flips data before the checker.
// - Transmit inversion flips the generated pattern.
// - One select field drives generator and checker.
// - Inject request corrupts one bit, then self-clears.
// - Ten errors in 48-bit window drop lock.
// - Forty-eight clean bits in a row gain lock.
// - Mismatch while locked sets the bit-error flag.
// - Any lock change sets the lock-change flag.
// - Bit-error enable gates flag bit 3 onto interrupt.
// - Lock-change enable gates flag bit 0 onto interrupt.
module e1_prbs_generator_detector (
   input wire logic MCLK,
   input wire logic RST,
   input wire pattern_gen_detect_pkg::reg_req_t REQ,
   output logic [7:0] RDATA,
   input wire logic TX_BIT_EN,
   output logic TX_DATA,
   output logic TX_VALID,
   input wire logic RX_BIT_EN,
   input wire logic RX_DATA,
   output logic INT
);
   import pattern_gen_detect_pkg::*;

   pattern_ctrl_t ctrl;
   logic bit_error_irq_en;
   logic lock_change_irq_en;
   logic single_error_inject;
   logic bit_error_flag;
   logic lock_change_flag;
   logic [19:0] gen_reg;
   logic [19:0] chk_reg;
   lock_state_t state;
   lock_state_t next_state;
   logic [5:0] win_cnt;
   logic [3:0] err_cnt;
   logic [5:0] run_cnt;
   logic [5:0] next_win_cnt;
   logic [3:0] next_err_cnt;
   logic [5:0] next_run_cnt;

   // Register decode.
   wire wr_ctrl = REQ.wr && (REQ.addr == PATTERN_CONTROL_OFS);
   wire wr_stat = REQ.wr && (REQ.addr == PATTERN_STATUS_ERROR_CONTROL_OFS);
   wire wr_flag = REQ.wr && (REQ.addr == PATTERN_EVENT_FLAGS_OFS);
   wire pattern_locked = (state == LOCKED);

   // Sequence choice shared by both directions.
   wire [4:0] seq_last = (ctrl.sequence_select == SEQ_2E20) ? SEQ20_LAST :
                         (ctrl.sequence_select == SEQ_2E11) ? SEQ11_LAST :
                         SEQ15_LAST;
   wire [4:0] seq_tap = (ctrl.sequence_select == SEQ_2E20) ? SEQ20_TAP :
                        (ctrl.sequence_select == SEQ_2E11) ? SEQ11_TAP :
                        SEQ15_TAP;

   // Generator feedback, inversion and single-bit corruption.
   wire gen_fb = gen_reg[seq_last] ^ gen_reg[seq_tap];
   wire gen_zero = (gen_reg == 20'h00000);
   wire [19:0] next_gen = gen_zero ? SHIFT_SEED : {gen_reg[18:0], gen_fb};
   wire tx_inverted = gen_fb ^ ctrl.tx_invert;
   wire next_tx = tx_inverted ^ single_error_inject;
   wire inject_done = TX_BIT_EN && single_error_inject;

   // Self-synchronising checker on the received stream.
   wire rx_bit = RX_DATA ^ ctrl.rx_invert;
   wire chk_expect = chk_reg[seq_last] ^ chk_reg[seq_tap];
   wire rx_err = RX_BIT_EN && (rx_bit != chk_expect);
   wire rx_clean = RX_BIT_EN && (rx_bit == chk_expect);
   wire win_end = (win_cnt == SYNC_WINDOW - 6'h01);
   wire [3:0] err_sum = err_cnt + {3'h0, rx_err};
   wire [5:0] run_sum = run_cnt + 6'h01;

   // Event detection and interrupt gating.
   wire bit_error_set = rx_err && pattern_locked;
   wire lock_change_set = (next_state != state);
   wire err_irq = bit_error_flag && bit_error_irq_en;
   wire lock_irq = lock_change_flag && lock_change_irq_en;
   wire next_int = err_irq || lock_irq;

   // Read multiplexer.
   wire [7:0] rd_ctrl = {4'h0, ctrl.rx_invert, ctrl.tx_invert,
                         ctrl.sequence_select};
   wire [7:0] rd_stat = {4'h0, bit_error_irq_en, single_error_inject,
                         pattern_locked, lock_change_irq_en};
   wire [7:0] rd_flag = {4'h0, bit_error_flag, 2'h0, lock_change_flag};
   wire [7:0] rd_mux =
      (REQ.addr == PATTERN_CONTROL_OFS) ? rd_ctrl :
      (REQ.addr == PATTERN_STATUS_ERROR_CONTROL_OFS) ? rd_stat :
      (REQ.addr == PATTERN_EVENT_FLAGS_OFS) ? rd_flag : 8'h00;

   // Lock state machine and its counters.
   always_comb begin
      next_state = state;
      next_win_cnt = win_cnt;
      next_err_cnt = err_cnt;
      next_run_cnt = run_cnt;
      case (state)
         HUNT: begin
            if (rx_err) begin
               next_run_cnt = 6'h00;
            end else if (rx_clean) begin
               next_run_cnt = run_sum;
               if (run_sum >= SYNC_CLEAN_RUN) begin
                  next_state = LOCKED;
                  next_win_cnt = 6'h00;
                  next_err_cnt = 4'h0;
               end
            end
         end
         LOCKED: begin
            if (RX_BIT_EN) begin
               next_err_cnt = err_sum;
               next_win_cnt = win_end ? 6'h00 : win_cnt + 6'h01;
               if (err_sum >= SYNC_LOSS_ERRORS) begin
                  next_state = HUNT;
                  next_run_cnt = 6'h00;
                  next_err_cnt = 4'h0;
               end else if (win_end) begin
                  next_err_cnt = 4'h0;
               end
            end
         end
         default: begin
            next_state = HUNT;
            next_run_cnt = 6'h00;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= HUNT;
         win_cnt <= 6'h00;
         err_cnt <= 4'h0;
         run_cnt <= 6'h00;
      end else begin
         state <= next_state;
         win_cnt <= next_win_cnt;
         err_cnt <= next_err_cnt;
         run_cnt <= next_run_cnt;
      end
   end

   // Control registers written by software.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctrl <= pattern_ctrl_t'(PATTERN_CONTROL_RESET[3:0]);
         bit_error_irq_en <= PATTERN_STATUS_ERROR_CONTROL_RESET[3];
         lock_change_irq_en <= PATTERN_STATUS_ERROR_CONTROL_RESET[0];
      end else begin
         if (wr_ctrl) begin
            ctrl <= pattern_ctrl_t'(REQ.wdata[3:0]);
         end
         if (wr_stat) begin
            bit_error_irq_en <= REQ.wdata[BIT_ERROR_IRQ_EN_BIT];
            lock_change_irq_en <= REQ.wdata[LOCK_CHANGE_IRQ_EN_BIT];
         end
      end
   end

   // Inject request: a write wins over the self-clear in the same cycle.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         single_error_inject <= PATTERN_STATUS_ERROR_CONTROL_RESET[2];
      end else if (wr_stat) begin
         single_error_inject <= REQ.wdata[SINGLE_ERROR_INJECT_BIT];
      end else if (inject_done) begin
         single_error_inject <= 1'b0;
      end
   end

   // Sticky flags: hardware set wins over a write-one clear.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         bit_error_flag <= PATTERN_EVENT_FLAGS_RESET[3];
         lock_change_flag <= PATTERN_EVENT_FLAGS_RESET[0];
      end else begin
         bit_error_flag <= bit_error_set ||
            (bit_error_flag && !(wr_flag && REQ.wdata[BIT_ERROR_FLAG_BIT]));
         lock_change_flag <= lock_change_set ||
            (lock_change_flag &&
             !(wr_flag && REQ.wdata[LOCK_CHANGE_FLAG_BIT]));
      end
   end

   // Pattern shift registers for both directions.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         gen_reg <= SHIFT_SEED;
         chk_reg <= SHIFT_SEED;
      end else begin
         if (TX_BIT_EN) begin
            gen_reg <= next_gen;
         end
         if (RX_BIT_EN) begin
            chk_reg <= {chk_reg[18:0], rx_bit};
         end
      end
   end

   // Registered outputs.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         TX_DATA <= 1'b0;
         TX_VALID <= 1'b0;
         RDATA <= 8'h00;
         INT <= 1'b0;
      end else begin
         TX_VALID <= TX_BIT_EN;
         if (TX_BIT_EN) begin
            TX_DATA <= next_tx;
         end
         RDATA <= REQ.rd ? rd_mux : 8'h00;
         INT <= next_int;
      end
   end

   a_rx_invert_path: assert property (
      @(posedge MCLK) disable iff (RST)
      (RX_BIT_EN && pattern_locked &&
       ((RX_DATA ^ ctrl.rx_invert) != chk_expect)) |=> bit_error_flag)
      else $error("Inverted receive mismatch did not flag an error.");

   a_tx_invert_out: assert property (
      @(posedge MCLK) disable iff (RST)
      (TX_BIT_EN && !single_error_inject) |=>
      (TX_DATA == ($past(gen_fb) ^ $past(ctrl.tx_invert))))
      else $error("Transmit bit does not follow inversion control.");

   a_seq_shared_len: assert property (
      @(posedge MCLK) disable iff (RST)
      (ctrl.sequence_select == SEQ_2E20) |-> (seq_last == 5'h13))
      else $error("Sequence select picked the wrong length.");

   a_inject_one_bit: assert property (
      @(posedge MCLK) disable iff (RST)
      (inject_done && !wr_stat) |=>
      (!single_error_inject &&
       TX_DATA == !($past(gen_fb) ^ $past(ctrl.tx_invert))))
      else $error("Error injection did not corrupt exactly one bit.");

   a_loss_threshold: assert property (
      @(posedge MCLK) disable iff (RST)
      (pattern_locked && RX_BIT_EN && rx_err && err_cnt == 4'h9) |=>
      (state == HUNT))
      else $error("Lock kept after ten errors in the window.");

   a_gain_after_run: assert property (
      @(posedge MCLK) disable iff (RST)
      (state == HUNT) ##1 (state == LOCKED) |->
      ($past(run_cnt) == 6'h2F))
      else $error("Lock gained without 48 clean bits.");

   a_lock_change_set: assert property (
      @(posedge MCLK) disable iff (RST)
      (state != $past(state)) |-> lock_change_flag)
      else $error("Lock change did not set its flag.");

   a_err_irq_gate: assert property (
      @(posedge MCLK) disable iff (RST)
      (bit_error_flag && bit_error_irq_en) |=> INT)
      else $error("Enabled bit-error flag did not raise interrupt.");

   a_lock_irq_gate: assert property (
      @(posedge MCLK) disable iff (RST)
      (lock_change_flag && lock_change_irq_en) |=> INT)
      else $error("Enabled lock-change flag did not raise interrupt.");

   a_int_released: assert property (
      @(posedge MCLK) disable iff (RST)
      !(err_irq || lock_irq) [*2] |-> !INT)
      else $error("Interrupt high with no enabled flag set.");

   a_rx_shift_in: assert property (
      @(posedge MCLK) disable iff (RST)
      RX_BIT_EN |=>
      (chk_reg[0] == ($past(RX_DATA) ^ $past(ctrl.rx_invert))))
      else $error("Received bit entered the checker with wrong polarity.");

   a_tx_valid_pulse: assert property (
      @(posedge MCLK) disable iff (RST)
      TX_VALID == $past(TX_BIT_EN))
      else $error("Transmit valid does not follow the bit enable.");

   a_reserved_code: assert property (
      @(posedge MCLK) disable iff (RST)
      (ctrl.sequence_select == 2'h3) |->
      (seq_last == SEQ15_LAST && seq_tap == SEQ15_TAP))
      else $error("Reserved select code did not fall back.");

   a_inject_waits: assert property (
      @(posedge MCLK) disable iff (RST)
      (single_error_inject && !TX_BIT_EN && !wr_stat) |=>
      single_error_inject)
      else $error("Inject request cleared before a bit went out.");

   a_window_wrap: assert property (
      @(posedge MCLK) disable iff (RST)
      (pattern_locked && RX_BIT_EN && win_end) |=>
      (win_cnt == 6'h00 && err_cnt == 4'h0))
      else $error("Error window did not restart after 48 bits.");

   a_run_restart: assert property (
      @(posedge MCLK) disable iff (RST)
      (state == HUNT && rx_err) |=> (run_cnt == 6'h00))
      else $error("Clean run count kept after an error.");

   a_err_flag_cause: assert property (
      @(posedge MCLK) disable iff (RST)
      $rose(bit_error_flag) |-> $past(pattern_locked && rx_err))
      else $error("Bit-error flag set without a locked mismatch.");

   a_lock_flag_hold: assert property (
      @(posedge MCLK) disable iff (RST)
      (lock_change_flag && !wr_flag) |=> lock_change_flag)
      else $error("Lock-change flag dropped without a clear.");

endmodule // e1_prbs_generator_detector

/* logic/pattern_gen_detect_pkg.sv */
// Package for the E1 pattern generator and detector: register map,
// field positions, reset values, sequence taps and shared types.
// Assumes a single 10 MHz clock and a byte-wide register port.
package pattern_gen_detect_pkg;

   // Register offsets on the byte-wide register port.
   localparam logic [7:0] PATTERN_CONTROL_OFS = 8'h71;
   localparam logic [7:0] PATTERN_STATUS_ERROR_CONTROL_OFS = 8'h72;
   localparam logic [7:0] PATTERN_EVENT_FLAGS_OFS = 8'h73;

   // Field positions of the pattern control register.
   localparam int RX_INVERT_BIT = 3;
   localparam int TX_INVERT_BIT = 2;
   localparam int SEQ_SELECT_LSB = 0;

   // Field positions of the status and error control register.
   localparam int BIT_ERROR_IRQ_EN_BIT = 3;
   localparam int SINGLE_ERROR_INJECT_BIT = 2;
   localparam int PATTERN_LOCKED_BIT = 1;
   localparam int LOCK_CHANGE_IRQ_EN_BIT = 0;

   // Field positions of the event flag register.
   localparam int BIT_ERROR_FLAG_BIT = 3;
   localparam int LOCK_CHANGE_FLAG_BIT = 0;

   // Values after reset.
   localparam logic [7:0] PATTERN_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PATTERN_STATUS_ERROR_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PATTERN_EVENT_FLAGS_RESET = 8'h00;
   localparam logic [19:0] SHIFT_SEED = 20'hFFFFF;

   // Lock criteria, counted in bit periods.
   localparam logic [5:0] SYNC_WINDOW = 6'h30;
   localparam logic [3:0] SYNC_LOSS_ERRORS = 4'hA;
   localparam logic [5:0] SYNC_CLEAN_RUN = 6'h30;

   // Sequence select codes.
   localparam logic [1:0] SEQ_2E15 = 2'h0;
   localparam logic [1:0] SEQ_2E20 = 2'h1;
   localparam logic [1:0] SEQ_2E11 = 2'h2;

   // Shift register taps as bit indices: last stage and feedback stage.
   localparam logic [4:0] SEQ15_LAST = 5'h0E;
   localparam logic [4:0] SEQ15_TAP = 5'h0D;
   localparam logic [4:0] SEQ20_LAST = 5'h13;
   localparam logic [4:0] SEQ20_TAP = 5'h10;
   localparam logic [4:0] SEQ11_LAST = 5'h0A;
   localparam logic [4:0] SEQ11_TAP = 5'h08;

   typedef enum logic [1:0] {
      HUNT = 2'b01,
      LOCKED = 2'b10
   } lock_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic rx_invert;
      logic tx_invert;
      logic [1:0] sequence_select;
   } pattern_ctrl_t;

endpackage

/* verif/e1_line_partner.sv */
// Behavioural model of the E1 line side: bit pacing and a loop from the
// transmit output back to the receive input.
// Assumes the block's registered TX_VALID pulse and a testbench flip control.
module e1_line_partner (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic TX_DATA,
   input wire logic TX_VALID,
   input wire logic flip,
   output logic TX_BIT_EN,
   output logic RX_BIT_EN,
   output logic RX_DATA
);
   timeunit 1ns;
   timeprecision 1ns;
   logic phase;
   // One bit every second clock; idle receive data shows the inverse value.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         phase <= 1'b0;
         TX_BIT_EN <= 1'b0;
         RX_BIT_EN <= 1'b0;
         RX_DATA <= 1'b0;
      end else begin
         phase <= ~phase;
         TX_BIT_EN <= phase;
         RX_BIT_EN <= TX_VALID;
         RX_DATA <= TX_VALID ? (TX_DATA ^ flip) : ~RX_DATA;
      end
   end
endmodule // e1_line_partner

/* verif/e1_prbs_generator_detector_tb_top.sv */
// Self-checking bench for the pattern generator and detector.
// Assumes the line partner loops transmit data back to the receiver.
module e1_prbs_generator_detector_tb_top;
   import pattern_gen_detect_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, flip, tx_bit_en, tx_data, tx_valid, rx_bit_en, rx_data;
   logic intr;
   logic [7:0] rdata;
   reg_req_t req;
   int fails = 0;
   int samples_checked = 0;
   localparam logic [7:0] CTL = PATTERN_CONTROL_OFS;
   localparam logic [7:0] STA = PATTERN_STATUS_ERROR_CONTROL_OFS;
   localparam logic [7:0] FLG = PATTERN_EVENT_FLAGS_OFS;

   e1_prbs_generator_detector u_e1_prbs_generator_detector (.MCLK(mclk),
      .RST(rst), .REQ(req), .RDATA(rdata), .TX_BIT_EN(tx_bit_en),
      .TX_DATA(tx_data), .TX_VALID(tx_valid), .RX_BIT_EN(rx_bit_en),
      .RX_DATA(rx_data), .INT(intr));
   e1_line_partner u_e1_line_partner (.MCLK(mclk), .RST(rst),
      .TX_DATA(tx_data), .TX_VALID(tx_valid), .flip(flip),
      .TX_BIT_EN(tx_bit_en), .RX_BIT_EN(rx_bit_en), .RX_DATA(rx_data));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      flip = 1'b0;
      req = '0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      // Reset values and an unmapped place.
      rd(CTL, 8'h00);
      rd(STA, 8'h00);
      rd(FLG, 8'h00);
      wr(8'h70, 8'hFF);
      rd(8'h70, 8'h00);
      wr(STA, 8'h01);
      // Each sequence code locks when both ends use it; code 3 acts as 0.
      for (int s = 0; s < 4; s++) begin
         wr(CTL, 8'(s));
         wt(300);
         rd(STA, 8'h03);
         rd(CTL, 8'(s));
         if (s == 0) begin
            rd(FLG, 8'h01);
            chk({7'h00, intr}, 8'h01);
            wr(FLG, 8'h01);
            wt(3);
            chk({7'h00, intr}, 8'h00);
         end
      end
      wr(FLG, 8'h09);
      // Inverted line data: every bit wrong, lock drops.
      flip <= 1'b1;
      wt(200);
      rd(STA, 8'h01);
      rd(FLG, 8'h09);
      chk({7'h00, intr}, 8'h01);
      wr(STA, 8'h00);
      wt(3);
      chk({7'h00, intr}, 8'h00);
      wr(STA, 8'h08);
      wt(3);
      chk({7'h00, intr}, 8'h01);
      wr(FLG, 8'h09);
      wt(3);
      chk({7'h00, intr}, 8'h00);
      rd(FLG, 8'h00);
      // Receive inversion undoes the line inversion.
      wr(CTL, 8'h0A);
      wt(300);
      rd(STA, 8'h0A);
      rd(FLG, 8'h01);
      chk({7'h00, intr}, 8'h00);
      flip <= 1'b0;
      wr(CTL, 8'h0E);
      wt(300);
      wr(FLG, 8'h09);
      wt(100);
      rd(STA, 8'h0A);
      wr(CTL, 8'h06);
      wt(200);
      rd(STA, 8'h08);
      wr(CTL, 8'h02);
      wt(300);
      wr(FLG, 8'h09);
      wt(100);
      rd(FLG, 8'h00);
      // One injected error: flag set, lock kept, request self-clears.
      wr(STA, 8'h0C);
      wt(60);
      rd(STA, 8'h0A);
      rd(FLG, 8'h08);
      chk({7'h00, intr}, 8'h01);
      wr(FLG, 8'h08);
      wt(3);
      chk({7'h00, intr}, 8'h00);
      report_and_stop();
   end
endmodule // e1_prbs_generator_detector_tb_top
